// ==== hdl/dgf_pkg.sv ====
// constants, types and the three-stage input filter of the dual gate command block
//
// Operation
// RULE_01: high-side and low-side channels run fully independently of each other.
// RULE_02: controller inserts dead-time between channel commands; no interlock here.
// RULE_03: primary undervoltage forces both status outputs low and all gates off.
// RULE_04: secondary undervoltage pulls that channel's status low and turns its gates off.
// RULE_05: adapter undervoltage turns that adapter off now, the others after a delay.
// RULE_06: commands are active high; rising edge turns on, falling edge turns off.
// RULE_07: status output stays high while no fault is present.
// RULE_08: short circuit or any undervoltage drives status low for exactly the blocking time.
// RULE_09: primary undervoltage holds status low throughout, then one more blocking time.
// RULE_10: no gate commands pass while a channel's status is held low.
// RULE_11: supply indicator lights only while the primary fifteen volt rail is present.
// RULE_12: fault indicator reflects short circuit or undervoltage on either side.
// RULE_13: fault indicator latches; clears on command rising edge once all is clear.
// RULE_14: short circuit turns gates off at once; status goes low after a delay.
// RULE_15: after blocking, gates turn on again only at the next turn-on command.
// RULE_16: blocking, status and adapter delays are counters sized by named constants.

package dgf_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int BLK_TIME_NS = 20000;
    localparam int SO_DELAY_NS = 1000;
    localparam int TOFF_DELAY_NS = 2000;
    localparam int BLK_CYC = (BLK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SO_CYC = (SO_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TOFF_CYC = (TOFF_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] BLK_LOAD = CNT_W'(BLK_CYC - 1);
    localparam logic [CNT_W-1:0] SO_LOAD = CNT_W'(SO_CYC - 1);
    localparam logic [CNT_W-1:0] TOFF_LOAD = CNT_W'(TOFF_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

    // ------------------------------------------------------------
    // input vector layout
    // ------------------------------------------------------------
    localparam int N_CH = 2;
    localparam int N_ADP = 4;
    localparam int SYNC_W = 16;
    localparam int IDX_CMD = 0;
    localparam int IDX_SC = 2;
    localparam int IDX_SUV = 4;
    localparam int IDX_AUV = 6;
    localparam int IDX_PUV = 14;
    localparam int IDX_RAIL = 15;
    localparam logic [N_ADP-1:0] ADP_ALL = 4'hF;
    localparam logic [N_ADP-1:0] ADP_NONE = 4'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_DELAY = 3'h2,
        ST_BLOCK = 3'h4
    } dgf_fsm_e;

    typedef struct packed {
        logic [N_CH-1:0] cmd_prev;
        dgf_fsm_e [N_CH-1:0] st;
        logic [N_CH-1:0][CNT_W-1:0] cnt;
        logic [N_CH-1:0][CNT_W-1:0] toff_cnt;
        logic [N_CH-1:0] toff_run;
        logic [N_CH-1:0] gate_req;
        logic [N_CH-1:0][N_ADP-1:0] adp_en;
        logic [N_CH-1:0] status;
        logic [N_CH-1:0][N_ADP-1:0] gate;
        logic fault_led;
        logic supply_led;
    } dgf_state_s;

    typedef struct packed {
        logic [SYNC_W-1:0] ff1;
        logic [SYNC_W-1:0] ff2;
        logic [SYNC_W-1:0] ff3;
        logic [SYNC_W-1:0] filt;
    } dgf_sync_s;
endpackage

`timescale 1ns/1ps

// three shift flops and one filter flop per pin; a bit changes once the second and third agree
module dgf_sync3 (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [dgf_pkg::SYNC_W-1:0] i_pins,
    output logic [dgf_pkg::SYNC_W-1:0] o_filt
);
    dgf_pkg::dgf_sync_s s_reg;
    dgf_pkg::dgf_sync_s s_next;

    // shift chain and agreement filter
    always_comb begin
        s_next = s_reg;
        s_next.ff1 = i_pins;
        s_next.ff2 = s_reg.ff1;
        s_next.ff3 = s_reg.ff2;
        s_next.filt = (s_reg.ff2 & s_reg.ff3) | (s_reg.filt & (s_reg.ff2 | s_reg.ff3));
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_filt = s_reg.filt;
endmodule // dgf_sync3

// ==== hdl/dgf_gate_ctrl.sv ====
// command forwarding, fault blocking and indicator logic of the dual gate driver
`timescale 1ns/1ps

module dgf_gate_ctrl (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_high_side_command_in,
    input wire logic i_low_side_command_in,
    input wire logic i_hs_short_circuit,
    input wire logic i_ls_short_circuit,
    input wire logic i_hs_secondary_undervoltage,
    input wire logic i_ls_secondary_undervoltage,
    input wire logic [3:0] i_hs_adapter_undervoltage,
    input wire logic [3:0] i_ls_adapter_undervoltage,
    input wire logic i_primary_undervoltage_lockout,
    input wire logic i_primary_fifteen_volt_rail,
    output logic o_high_side_status_out,
    output logic o_low_side_status_out,
    output logic [3:0] o_hs_gate_on,
    output logic [3:0] o_ls_gate_on,
    output logic o_supply_led,
    output logic o_fault_led
);
    // ------------------------------------------------------------
    // input filtering
    // ------------------------------------------------------------
    logic [dgf_pkg::SYNC_W-1:0] pins;
    logic [dgf_pkg::SYNC_W-1:0] filt;
    logic [1:0] f_cmd;
    logic [1:0] f_sc;
    logic [1:0] f_suv;
    logic [1:0][3:0] f_auv;
    logic f_puv;
    logic f_rail;
    logic [1:0] rise;
    logic [1:0] fall;
    logic any_fault;
    dgf_pkg::dgf_state_s r_reg;
    dgf_pkg::dgf_state_s r_next;

    // pin bundle into the filter
    assign pins = {i_primary_fifteen_volt_rail, i_primary_undervoltage_lockout,
                   i_ls_adapter_undervoltage, i_hs_adapter_undervoltage,
                   i_ls_secondary_undervoltage, i_hs_secondary_undervoltage,
                   i_ls_short_circuit, i_hs_short_circuit,
                   i_low_side_command_in, i_high_side_command_in};

    dgf_sync3 u_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_pins(pins),
        .o_filt(filt)
    );

    // filtered fields
    assign f_cmd = filt[dgf_pkg::IDX_CMD +: 2];
    assign f_sc = filt[dgf_pkg::IDX_SC +: 2];
    assign f_suv = filt[dgf_pkg::IDX_SUV +: 2];
    assign f_auv = filt[dgf_pkg::IDX_AUV +: 8];
    assign f_puv = filt[dgf_pkg::IDX_PUV];
    assign f_rail = filt[dgf_pkg::IDX_RAIL];

    // command edges, one detector per channel
    assign rise = f_cmd & ~r_reg.cmd_prev; // [RULE_06]
    assign fall = ~f_cmd & r_reg.cmd_prev; // [RULE_06]
    assign any_fault = f_puv | (|f_sc) | (|f_suv) | (|f_auv);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // each channel reads only its own inputs, the shared primary undervoltage and its own state
    always_comb begin
        r_next = r_reg;
        r_next.cmd_prev = f_cmd;
        for (int c = 0; c < dgf_pkg::N_CH; c++) begin // [RULE_01]
            // adapter undervoltage: that adapter off now
            r_next.adp_en[c] = r_reg.adp_en[c] & ~f_auv[c]; // [RULE_05]
            // remaining adapters follow after the turn-off delay
            if (r_reg.toff_run[c]) begin
                if (r_reg.toff_cnt[c] == dgf_pkg::CNT_ZERO) begin
                    r_next.toff_run[c] = 1'b0;
                    r_next.gate_req[c] = 1'b0; // [RULE_05]
                end else begin
                    r_next.toff_cnt[c] = r_reg.toff_cnt[c] - dgf_pkg::CNT_ONE; // [RULE_16]
                end
            end else if (|f_auv[c]) begin
                r_next.toff_run[c] = 1'b1;
                r_next.toff_cnt[c] = dgf_pkg::TOFF_LOAD; // [RULE_16]
            end
            // fault sequencer
            case (r_reg.st[c])
                dgf_pkg::ST_IDLE: begin
                    if (f_puv || f_suv[c] || (|f_auv[c])) begin
                        r_next.st[c] = dgf_pkg::ST_BLOCK; // [RULE_04]
                        r_next.cnt[c] = dgf_pkg::BLK_LOAD; // [RULE_08]
                    end else if (f_sc[c]) begin
                        r_next.st[c] = dgf_pkg::ST_DELAY; // [RULE_14]
                        r_next.cnt[c] = dgf_pkg::SO_LOAD;
                    end else if (rise[c]) begin
                        r_next.gate_req[c] = 1'b1; // [RULE_06] [RULE_15]
                        r_next.adp_en[c] = dgf_pkg::ADP_ALL;
                    end
                end
                dgf_pkg::ST_DELAY: begin
                    if (f_puv || f_suv[c] || (|f_auv[c]) || r_reg.cnt[c] == dgf_pkg::CNT_ZERO) begin
                        r_next.st[c] = dgf_pkg::ST_BLOCK; // [RULE_14]
                        r_next.cnt[c] = dgf_pkg::BLK_LOAD;
                    end else begin
                        r_next.cnt[c] = r_reg.cnt[c] - dgf_pkg::CNT_ONE; // [RULE_16]
                    end
                end
                dgf_pkg::ST_BLOCK: begin
                    // rising edges are dropped in here
                    if (f_puv) begin
                        r_next.cnt[c] = dgf_pkg::BLK_LOAD; // [RULE_09]
                    end else if (r_reg.cnt[c] == dgf_pkg::CNT_ZERO) begin
                        r_next.st[c] = dgf_pkg::ST_IDLE; // [RULE_08] [RULE_10]
                    end else begin
                        r_next.cnt[c] = r_reg.cnt[c] - dgf_pkg::CNT_ONE; // [RULE_16]
                    end
                end
                default: begin
                    r_next.st[c] = dgf_pkg::ST_IDLE;
                    r_next.cnt[c] = dgf_pkg::CNT_ZERO;
                end
            endcase
            // immediate turn-off on hard faults and on command fall
            if (f_puv || f_suv[c] || f_sc[c] || fall[c]) begin
                r_next.gate_req[c] = 1'b0; // [RULE_03] [RULE_04] [RULE_14] [RULE_06]
            end
            r_next.status[c] = (r_next.st[c] != dgf_pkg::ST_BLOCK); // [RULE_07] [RULE_08]
            r_next.gate[c] = r_next.gate_req[c] ? r_next.adp_en[c] : dgf_pkg::ADP_NONE;
        end
        // indicators; a new fault wins over a clear
        r_next.supply_led = f_rail; // [RULE_11]
        if (any_fault) begin
            r_next.fault_led = 1'b1; // [RULE_12] [RULE_13]
        end else if ((|rise) && !f_puv && (&r_reg.status)) begin
            r_next.fault_led = 1'b0; // [RULE_13]
        end
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r_reg <= '0;
            r_reg.st[0] <= dgf_pkg::ST_IDLE;
            r_reg.st[1] <= dgf_pkg::ST_IDLE;
            r_reg.status <= 2'h3;
        end else begin
            r_reg <= r_next;
        end
    end

    // outputs, all from flops
    assign o_high_side_status_out = r_reg.status[0];
    assign o_low_side_status_out = r_reg.status[1];
    assign o_hs_gate_on = r_reg.gate[0];
    assign o_ls_gate_on = r_reg.gate[1];
    assign o_supply_led = r_reg.supply_led;
    assign o_fault_led = r_reg.fault_led;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    localparam int BLK_A = dgf_pkg::BLK_CYC;
    localparam int SO_A = dgf_pkg::SO_CYC;
    localparam int TOFF_A1 = dgf_pkg::TOFF_CYC + 1;
    logic [1:0][11:0] low_cnt;

    // length of each low status stretch, restarted by primary undervoltage
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            low_cnt <= '0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (r_reg.status[c] || f_puv) begin
                    low_cnt[c] <= 12'h000;
                end else begin
                    low_cnt[c] <= low_cnt[c] + 12'h001;
                end
            end
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_puv_status_low: assert property (f_puv |=> (r_reg.status == 2'h0)) // [RULE_03]
        else $error("status high during primary undervoltage");
    a_puv_gates_off: assert property (f_puv |=> (r_reg.gate == '0)) // [RULE_03]
        else $error("gate on during primary undervoltage");
    a_supply_led_follow: assert property (##1 (o_supply_led == $past(f_rail))) // [RULE_11]
        else $error("supply indicator does not follow rail");
    a_fault_led_set: assert property (any_fault |=> o_fault_led) // [RULE_12]
        else $error("fault indicator not set");
    a_fault_led_hold: assert property (o_fault_led && !(|rise) |=> o_fault_led) // [RULE_13]
        else $error("fault indicator cleared without command edge");

    for (genvar g = 0; g < 2; g++) begin : g_chk
        sequence s_sc_start;
            (r_reg.st[g] == dgf_pkg::ST_IDLE) && f_sc[g] && !f_puv && !f_suv[g] && !(|f_auv[g]);
        endsequence
        sequence s_status_drop;
            ##(SO_A) !r_reg.status[g];
        endsequence
        a_sc_gate_off: assert property (f_sc[g] |=> (r_reg.gate[g] == '0)) // [RULE_14]
            else $error("gate still on after short circuit");
        a_sc_status_delay: assert property (s_sc_start |=> s_status_drop) // [RULE_14]
            else $error("status not low after status delay");
        a_blk_length: assert property ($rose(r_reg.status[g]) |-> (low_cnt[g] == BLK_A)) // [RULE_08] [RULE_09]
            else $error("status low stretch not equal to blocking time");
        a_suv_channel_off: assert property (f_suv[g] |=> !r_reg.status[g] && (r_reg.gate[g] == '0)) // [RULE_04]
            else $error("secondary undervoltage not handled");
        a_blocked_no_turnon: assert property (!r_reg.status[g] |=> !$rose(|r_reg.gate[g])) // [RULE_10]
            else $error("gate turned on while status low");
        a_rise_turn_on: assert property ((r_reg.st[g] == dgf_pkg::ST_IDLE) && rise[g] && !any_fault
            |=> (r_reg.gate[g] == dgf_pkg::ADP_ALL)) // [RULE_06]
            else $error("rising command did not turn gates on");
        a_fall_turn_off: assert property (fall[g] |=> (r_reg.gate[g] == '0)) // [RULE_06]
            else $error("falling command did not turn gates off");
        a_no_auto_on: assert property (!rise[g] |=> !$rose(|r_reg.gate[g])) // [RULE_15]
            else $error("gate turned on without command");
        a_adapter_now: assert property ((f_auv[g] != 4'h0) |=> ((r_reg.gate[g] & $past(f_auv[g])) == 4'h0)) // [RULE_05]
            else $error("failed adapter not turned off at once");
        a_adapter_rest: assert property ((f_auv[g] != 4'h0) && !r_reg.toff_run[g]
            |-> ##[1:TOFF_A1] (r_reg.gate[g] == '0)) // [RULE_05]
            else $error("remaining adapters not off after turn-off delay");
    end
endmodule // dgf_gate_ctrl

// ==== testbench/dgf_ctrl_model.sv ====
// controller model that drives both command inputs and keeps dead-time between them
`timescale 1ns/1ps

module dgf_ctrl_model #(
    parameter int DEAD_CYC = 8
) (
    input wire logic i_clk,
    output logic o_hs_cmd,
    output logic o_ls_cmd
);
    // both commands start off
    initial begin
        o_hs_cmd = 1'b0;
        o_ls_cmd = 1'b0;
    end

    // a turn-on first drops the other channel and waits out the dead-time
    task automatic set_cmd(input bit hs, input logic val);
        @(posedge i_clk);
        if (val) begin
            if (hs) o_ls_cmd <= 1'b0;
            else o_hs_cmd <= 1'b0;
            repeat (DEAD_CYC) @(posedge i_clk);
        end
        if (hs) o_hs_cmd <= val;
        else o_ls_cmd <= val;
        repeat (8) @(posedge i_clk);
        #1;
    endtask
endmodule // dgf_ctrl_model

// ==== testbench/test_dual_gate_command_fault_status.sv ====
// self-checking bench of the dual gate command and fault status block
`timescale 1ns/1ps

module test_dual_gate_command_fault_status;
    logic clk, rst_n, sc_hs, sc_ls, suv_hs, suv_ls, puv, rail;
    logic [3:0] auv_hs, auv_ls, gate_hs, gate_ls;
    logic hs_cmd, ls_cmd, so_hs, so_ls, led_sup, led_flt;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    int n;

    // ------------------------------------------------------------
    // clock, partner and design
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    dgf_ctrl_model i_ctrl (.i_clk(clk), .o_hs_cmd(hs_cmd), .o_ls_cmd(ls_cmd));

    dgf_gate_ctrl i_dut (
        .i_clk(clk), .i_rst_n(rst_n),
        .i_high_side_command_in(hs_cmd), .i_low_side_command_in(ls_cmd),
        .i_hs_short_circuit(sc_hs), .i_ls_short_circuit(sc_ls),
        .i_hs_secondary_undervoltage(suv_hs), .i_ls_secondary_undervoltage(suv_ls),
        .i_hs_adapter_undervoltage(auv_hs), .i_ls_adapter_undervoltage(auv_ls),
        .i_primary_undervoltage_lockout(puv), .i_primary_fifteen_volt_rail(rail),
        .o_high_side_status_out(so_hs), .o_low_side_status_out(so_ls),
        .o_hs_gate_on(gate_hs), .o_ls_gate_on(gate_ls),
        .o_supply_led(led_sup), .o_fault_led(led_flt)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // cycle ceiling against a hang
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            err_count++;
            finish_test();
        end
    end

    task automatic wt(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // waits for a status to drop, then counts the cycles it stays low
    task automatic low_len(input bit hs, output int len);
        int k;
        len = 0;
        for (k = 0; k < 100 && (hs ? so_hs : so_ls) !== 1'b0; k++) wt(1);
        while ((hs ? so_hs : so_ls) === 1'b0 && len < 3000) begin
            wt(1);
            len++;
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check({so_hs, so_ls, led_sup, led_flt}, 4'hE, "reset outputs");
        check(gate_hs | gate_ls, 4'h0, "reset gates");
        @(posedge clk) rail <= 1'b0;
        wt(6);
        check(led_sup, 1'b0, "supply led off");
        @(posedge clk) rail <= 1'b1;
        wt(6);
        check(led_sup, 1'b1, "supply led on");
        $display("test reset done");
    endtask

    task automatic t_cmd();
        i_ctrl.set_cmd(1, 1'b1);
        check(gate_hs, 4'hF, "hs on");
        check(gate_ls, 4'h0, "ls stays off");
        i_ctrl.set_cmd(1, 1'b0);
        check(gate_hs, 4'h0, "hs off");
        i_ctrl.set_cmd(0, 1'b1);
        check(gate_ls, 4'hF, "ls on");
        i_ctrl.set_cmd(0, 1'b0);
        check(gate_ls, 4'h0, "ls off");
        $display("test commands done");
    endtask

    task automatic t_sc();
        i_ctrl.set_cmd(1, 1'b1);
        @(posedge clk) sc_hs <= 1'b1;
        repeat (4) @(posedge clk);
        sc_hs <= 1'b0;
        wt(2);
        check(gate_hs, 4'h0, "sc gate off");
        check(led_flt, 1'b1, "fault led set");
        wt(30);
        check(so_hs, 1'b1, "status delayed");
        wt(20);
        check(so_hs, 1'b0, "status low");
        check(so_ls, 1'b1, "ls status untouched");
        i_ctrl.set_cmd(1, 1'b0);
        i_ctrl.set_cmd(1, 1'b1);
        check(gate_hs, 4'h0, "no rise in blocking");
        low_len(1, n);
        wt(4);
        check(gate_hs, 4'h0, "no auto turn-on");
        check(led_flt, 1'b1, "fault led latched");
        i_ctrl.set_cmd(1, 1'b0);
        i_ctrl.set_cmd(1, 1'b1);
        check(gate_hs, 4'hF, "on at next rise");
        check(led_flt, 1'b0, "fault led cleared");
        $display("test short circuit done");
    endtask

    task automatic t_adp();
        @(posedge clk) auv_hs <= 4'h2;
        wt(6);
        check(gate_hs, 4'hD, "adapter off at once");
        check(so_hs, 1'b0, "adapter status low");
        @(posedge clk) auv_hs <= 4'h0;
        wt(dgf_pkg::TOFF_CYC);
        check(gate_hs, 4'h0, "others off later");
        low_len(1, n);
        $display("test adapter done");
    endtask

    task automatic t_suv();
        i_ctrl.set_cmd(1, 1'b0);
        i_ctrl.set_cmd(1, 1'b1);
        @(posedge clk) suv_ls <= 1'b1;
        repeat (3) @(posedge clk);
        suv_ls <= 1'b0;
        low_len(0, n);
        check(n[11:0], 12'(dgf_pkg::BLK_CYC), "blocking length");
        check({so_hs, gate_hs}, 5'h1F, "hs untouched");
        check(gate_ls, 4'h0, "ls gate off");
        $display("test secondary undervoltage done");
    endtask

    // fault indicator stays lit while the other channel still blocks
    task automatic t_led();
        @(posedge clk) suv_ls <= 1'b1;
        repeat (3) @(posedge clk);
        suv_ls <= 1'b0;
        wt(10);
        check(so_ls, 1'b0, "ls blocking");
        i_ctrl.set_cmd(1, 1'b0);
        i_ctrl.set_cmd(1, 1'b1);
        check(gate_hs, 4'hF, "hs on beside ls fault");
        check(led_flt, 1'b1, "led kept while ls low");
        low_len(0, n);
        i_ctrl.set_cmd(1, 1'b0);
        i_ctrl.set_cmd(1, 1'b1);
        check(led_flt, 1'b0, "led cleared once clear");
        $display("test fault indicator done");
    endtask

    task automatic t_puv();
        @(posedge clk) puv <= 1'b1;
        wt(6);
        check({so_hs, so_ls}, 2'h0, "both status low");
        check(gate_hs | gate_ls, 4'h0, "all gates off");
        wt(100);
        check({so_hs, so_ls}, 2'h0, "low during lockout");
        @(posedge clk) puv <= 1'b0;
        wt(795);
        check({so_hs, so_ls}, 2'h0, "extended low");
        wt(15);
        check({so_hs, so_ls}, 2'h3, "status back high");
        $display("test primary undervoltage done");
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, sc_hs, sc_ls, suv_hs, suv_ls, puv} = 6'h00;
        rail = 1'b1;
        auv_hs = 4'h0;
        auv_ls = 4'h0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        wt(8);
        t_reset();
        t_cmd();
        t_sc();
        t_adp();
        t_suv();
        t_led();
        t_puv();
        finish_test();
    end
endmodule // test_dual_gate_command_fault_status
